/* File: core/ptsc_timestamp_if.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - with in-band enabled, the beat before a frame is its 64-bit command, consumed
// - preamble preserve wins: in-band command is then treated as off
// - in-band off: command comes from user bits 127:64
// - user bit 0 is underrun, user bits 63:1 are ignored
// - one-step or two-step frames return timestamp and tag on the stamp stream
// - calendar stamp: nanos 31:0, seconds 79:32, tag 95:80, 127:96 reserved
// - correction stamp: time 63:0, 79:64 reserved, tag 95:80
// - stamp payload is meaningful only while its valid is high
// - receive in-line option puts a 64-bit stamp word before the frame when rx preamble preserve is off
// - calendar in-line word: nanos in 31:0, low seconds in 63:32
// - every received frame gets a stamp on the receive stamp stream
// - calendar receive stamp: seconds 79:32, nanos 31:0, 127:80 reserved
// - receive stamp valid coincides with the frame's first output beat
// - first receive beat is stamp word when in-line, else address fields
// - time inputs live in the timer's own domain and are synchronised into mclk
// - all client streams are synchronous to the one datapath clock
// - command bits 1:0: none, one-step, two-step, three acts as none
// - two-step tag is command bits 31:16, returned unchanged
module ptsc_timestamp_if
	import ptsc_pkg::*;
#(
	parameter bit         CAL_FORMAT = 1'b1,
	parameter int         BUS_W      = DATA_W
) (
	input  wire logic                  mclk,
	input  wire logic                  reset_n,
	input  wire logic                  txInbandCmdEn,
	input  wire logic                  txPreservePreambleEn,
	input  wire logic                  rxInlineStampEn,
	input  wire logic                  rxPreservePreambleEn,
	input  wire logic [NANOS_W-1:0]    calendar_nanos_in,
	input  wire logic [SECS_W-1:0]     calendarSecsIn,
	input  wire logic [CORR_W-1:0]     correctionTimeIn,
	input  wire logic [DATA_W-1:0]     txInData,
	input  wire logic [KEEP_W-1:0]     txInKeep,
	input  wire logic                  txInLast,
	input  wire logic [USER_W-1:0]     txInUser,
	input  wire logic                  txInValid,
	output logic                       txInReady,
	output logic [DATA_W-1:0]          txOutData,
	output logic [KEEP_W-1:0]          txOutKeep,
	output logic                       txOutLast,
	output logic                       txOutUnderrun,
	output logic                       txOutValid,
	input  wire logic                  txOutReady,
	output logic [STAMP_W-1:0]         tx_stamp_payload,
	output logic                       tx_stamp_valid,
	input  wire logic [DATA_W-1:0]     rxInData,
	input  wire logic [KEEP_W-1:0]     rxInKeep,
	input  wire logic                  rxInLast,
	input  wire logic                  rxInErr,
	input  wire logic                  rxInValid,
	output logic [DATA_W-1:0]          rxOutData,
	output logic [KEEP_W-1:0]          rxOutKeep,
	output logic                       rxOutLast,
	output logic                       rxOutErr,
	output logic                       rxOutValid,
	output logic [STAMP_W-1:0]         rx_stamp_payload,
	output logic                       rx_stamp_valid
);

	generate
		if (BUS_W != DATA_W) begin : g_bad_width
			$error("only a 64-bit stream is supported");
		end
	endgenerate

	ptsc_state_t        st_r;
	ptsc_state_t        st_nxt;
	logic [TIME_W-1:0]  timeRaw;
	logic               txInbandEff;
	logic               rxInlineEff;
	logic               txOutOpen;
	logic               txFire;
	logic               cmdBeatFire;
	logic               txFirstFire;
	logic [CMD_W-1:0]   cmdWord;
	logic               stampWanted;
	logic               rxFirst;

	// both formats share one 80-bit carrier; correction keeps the top 16 bits zero
	assign timeRaw     = CAL_FORMAT ? {calendarSecsIn, calendar_nanos_in}
	                                : {16'h0000, correctionTimeIn};
	assign txInbandEff = txInbandCmdEn && !txPreservePreambleEn;
	assign rxInlineEff = rxInlineStampEn && !rxPreservePreambleEn;
	assign txOutOpen   = !st_r.txOutValid || txOutReady;
	assign txInReady   = txOutOpen;
	assign txFire      = txInValid && txOutOpen;
	assign cmdBeatFire = txFire && st_r.txState == TX_IDLE && txInbandEff;
	assign txFirstFire = txFire && !cmdBeatFire && st_r.txState != TX_FRAME;
	// held in-band word wins even if the option dropped after it was taken
	assign cmdWord     = (st_r.txState == TX_CMD_HELD) ? st_r.heldCmd
	                                                   : txInUser[CMD_LO +: CMD_W];
	assign stampWanted = cmdWord[1:0] == OP_ONE_STEP || cmdWord[1:0] == OP_TWO_STEP;
	assign rxFirst     = rxInValid && !st_r.rxInFrame;

	always_comb begin
		st_nxt = st_r;

		// a multi-bit word is only taken once two synchronised samples agree,
		// so a value torn across a timer update never reaches the stamps
		st_nxt.sync1 = timeRaw;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.sync3 = st_r.sync2;
		if (st_r.sync2 == st_r.sync3) begin
			st_nxt.timeNow = st_r.sync3;
		end

		st_nxt.txStampValid = 1'b0;
		if (txOutOpen) begin
			st_nxt.txOutValid = txFire && !cmdBeatFire;
		end
		if (txFire) begin
			unique case (st_r.txState)
				TX_IDLE: begin
					if (cmdBeatFire) begin
						st_nxt.heldCmd = txInData;
						st_nxt.txState = TX_CMD_HELD;
					end else begin
						st_nxt.txState = txInLast ? TX_IDLE : TX_FRAME;
					end
				end
				TX_CMD_HELD: begin
					st_nxt.txState = txInLast ? TX_IDLE : TX_FRAME;
				end
				TX_FRAME: begin
					st_nxt.txState = txInLast ? TX_IDLE : TX_FRAME;
				end
			endcase
			if (!cmdBeatFire) begin
				st_nxt.txOutData     = txInData;
				st_nxt.txOutKeep     = txInKeep;
				st_nxt.txOutLast     = txInLast;
				st_nxt.txOutUnderrun = txInUser[UNDERRUN_B];
			end
		end
		if (txFirstFire && stampWanted) begin
			st_nxt.txStampValid   = 1'b1;
			// reserved fields stay zero; correction leaves 79:64 zero via the carrier
			st_nxt.txStampPayload = {32'h0000_0000, cmdWord[TAG_LO +: TAG_W],
			                         st_r.timeNow};
		end

		if (rxInValid) begin
			st_nxt.rxInFrame = !rxInLast;
		end
		st_nxt.rxStampValid = rxFirst;
		if (rxFirst) begin
			st_nxt.rxStampPayload = {48'h0000_0000_0000, st_r.timeNow};
		end
		// the in-line word costs one beat; the pending beat drains in the
		// next gap, so frames need at least one idle cycle between them
		st_nxt.rxOutFirst = 1'b0;
		if (st_r.rxHoldValid) begin
			st_nxt.rxOutValid  = 1'b1;
			st_nxt.rxOutData   = st_r.rxHoldData;
			st_nxt.rxOutKeep   = st_r.rxHoldKeep;
			st_nxt.rxOutLast   = st_r.rxHoldLast;
			st_nxt.rxOutErr    = st_r.rxHoldErr;
			st_nxt.rxHoldValid = rxInValid;
			st_nxt.rxHoldData  = rxInData;
			st_nxt.rxHoldKeep  = rxInKeep;
			st_nxt.rxHoldLast  = rxInLast;
			st_nxt.rxHoldErr   = rxInErr;
		end else if (rxFirst && rxInlineEff) begin
			st_nxt.rxOutValid  = 1'b1;
			st_nxt.rxOutData   = st_r.timeNow[INLINE_W-1:0];
			st_nxt.rxOutKeep   = '1;
			st_nxt.rxOutLast   = 1'b0;
			st_nxt.rxOutErr    = 1'b0;
			st_nxt.rxOutFirst  = 1'b1;
			st_nxt.rxHoldValid = 1'b1;
			st_nxt.rxHoldData  = rxInData;
			st_nxt.rxHoldKeep  = rxInKeep;
			st_nxt.rxHoldLast  = rxInLast;
			st_nxt.rxHoldErr   = rxInErr;
		end else begin
			st_nxt.rxOutValid = rxInValid;
			st_nxt.rxOutData  = rxInData;
			st_nxt.rxOutKeep  = rxInKeep;
			st_nxt.rxOutLast  = rxInLast;
			st_nxt.rxOutErr   = rxInErr;
			st_nxt.rxOutFirst = rxFirst;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign txOutData        = st_r.txOutData;
	assign txOutKeep        = st_r.txOutKeep;
	assign txOutLast        = st_r.txOutLast;
	assign txOutUnderrun    = st_r.txOutUnderrun;
	assign txOutValid       = st_r.txOutValid;
	assign tx_stamp_payload = st_r.txStampPayload;
	assign tx_stamp_valid   = st_r.txStampValid;
	assign rxOutData        = st_r.rxOutData;
	assign rxOutKeep        = st_r.rxOutKeep;
	assign rxOutLast        = st_r.rxOutLast;
	assign rxOutErr         = st_r.rxOutErr;
	assign rxOutValid       = st_r.rxOutValid;
	assign rx_stamp_payload = st_r.rxStampPayload;
	assign rx_stamp_valid   = st_r.rxStampValid;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence s_tx_stamp_cause;
		txFirstFire && stampWanted;
	endsequence

	sequence s_tx_cmd_taken;
		cmdBeatFire;
	endsequence

	sequence s_rx_plain_start;
		rxFirst && !rxInlineEff && !st_r.rxHoldValid;
	endsequence

	sequence s_rx_inline_start;
		rxFirst && rxInlineEff && !st_r.rxHoldValid;
	endsequence

	// a fresh cause may renew the pulse for a back-to-back single-beat frame
	a_tx_stamp_pulse: assert property (
		tx_stamp_valid && !(txFirstFire && stampWanted) |=> !tx_stamp_valid
	)
		else $error("transmit stamp valid held past one cycle");
	a_tx_stamp_cause: assert property (s_tx_stamp_cause |=> tx_stamp_valid)
		else $error("stamped frame gave no transmit stamp");
	a_tx_no_nop: assert property (tx_stamp_valid |-> $past(txFirstFire && stampWanted))
		else $error("transmit stamp without one-step or two-step command");
	a_tx_tag_field: assert property (
		s_tx_stamp_cause |=> tx_stamp_payload[95:80] == $past(cmdWord[31:16])
	)
		else $error("transmit stamp tag differs from command tag");
	a_tx_time_field: assert property (
		s_tx_stamp_cause |=> tx_stamp_payload[79:0] == $past(st_r.timeNow)
	)
		else $error("transmit stamp time differs from sampled time");
	a_tx_reserved: assert property (tx_stamp_valid |-> tx_stamp_payload[127:96] == '0)
		else $error("transmit stamp reserved bits not zero");
	a_tx_corr_gap: assert property (
		tx_stamp_valid && !CAL_FORMAT |-> tx_stamp_payload[79:64] == '0
	)
		else $error("correction stamp gap bits not zero");
	a_tx_cmd_hidden: assert property (
		s_tx_cmd_taken |=> txOutValid == $past(txOutValid && !txOutReady)
	)
		else $error("in-band command beat reached the transmit output");
	a_preamble_wins: assert property (
		txFire && st_r.txState == TX_IDLE && txInbandCmdEn && txPreservePreambleEn
		|=> txOutValid && txOutData == $past(txInData)
	)
		else $error("beat consumed as command while preamble preserve is on");
	a_tx_forward: assert property (
		txFire && !cmdBeatFire |=> txOutValid && txOutData == $past(txInData)
	)
		else $error("accepted data beat not forwarded");
	a_tx_stall_hold: assert property (
		txOutValid && !txOutReady |-> !txInReady ##1 (txOutValid && $stable(txOutData))
	)
		else $error("stalled transmit beat not held");
	a_underrun_map: assert property (
		txFire && !cmdBeatFire |=> txOutUnderrun == $past(txInUser[0])
	)
		else $error("underrun flag not taken from user bit 0");
	a_rx_stamp_first: assert property (rx_stamp_valid == (rxOutValid && st_r.rxOutFirst))
		else $error("receive stamp valid not on first output beat");
	a_rx_every_frame: assert property (
		rxFirst |=> rx_stamp_valid ##1 (!rx_stamp_valid || $past(rxFirst))
	)
		else $error("received frame without a one-cycle stamp");
	a_rx_stamp_time: assert property (
		rxFirst |=> rx_stamp_payload[79:0] == $past(st_r.timeNow)
	)
		else $error("receive stamp time differs from sampled time");
	a_rx_plain_first: assert property (
		s_rx_plain_start |=> rxOutValid && rxOutData == $past(rxInData)
	)
		else $error("first receive beat is not the frame's first beat");
	a_rx_inline_next: assert property (
		s_rx_inline_start |=> (rxOutValid && !rxOutLast) ##1
		(rxOutValid && rxOutData == $past(rxInData, 2))
	)
		else $error("frame beat does not follow the in-line word");
	a_rx_inline_word: assert property (
		rxFirst && rxInlineEff |=> rxOutData == rx_stamp_payload[63:0]
	)
		else $error("in-line word differs from captured stamp");
	a_rx_reserved: assert property (rx_stamp_valid |-> rx_stamp_payload[127:80] == '0)
		else $error("receive stamp reserved bits not zero");
	a_time_stable: assert property (
		$changed(st_r.timeNow) |-> $past(st_r.sync2 == st_r.sync3)
	)
		else $error("time taken before two samples agreed");

endmodule

/* File: core/ptsc_pkg.sv */
package ptsc_pkg;
	localparam int          DATA_W      = 64;
	localparam int          KEEP_W      = DATA_W / 8;
	localparam int          USER_W      = 128;
	localparam int          CMD_W       = 64;
	localparam int          CMD_LO      = 64;
	localparam int          UNDERRUN_B  = 0;
	localparam int          TAG_LO      = 16;
	localparam int          TAG_W       = 16;
	localparam int          STAMP_W     = 128;
	localparam int          TIME_W      = 80;
	localparam int          NANOS_W     = 32;
	localparam int          SECS_W      = 48;
	localparam int          CORR_W      = 64;
	localparam int          INLINE_W    = 64;
	localparam logic [1:0]  OP_ONE_STEP = 2'h1;
	localparam logic [1:0]  OP_TWO_STEP = 2'h2;

	typedef enum logic [1:0] {TX_IDLE, TX_CMD_HELD, TX_FRAME} ptsc_tx_state_t;

	typedef struct packed {
		logic [TIME_W-1:0]  sync1;
		logic [TIME_W-1:0]  sync2;
		logic [TIME_W-1:0]  sync3;
		logic [TIME_W-1:0]  timeNow;
		ptsc_tx_state_t     txState;
		logic [CMD_W-1:0]   heldCmd;
		logic               txOutValid;
		logic [DATA_W-1:0]  txOutData;
		logic [KEEP_W-1:0]  txOutKeep;
		logic               txOutLast;
		logic               txOutUnderrun;
		logic               txStampValid;
		logic [STAMP_W-1:0] txStampPayload;
		logic               rxInFrame;
		logic               rxHoldValid;
		logic [DATA_W-1:0]  rxHoldData;
		logic [KEEP_W-1:0]  rxHoldKeep;
		logic               rxHoldLast;
		logic               rxHoldErr;
		logic               rxOutValid;
		logic [DATA_W-1:0]  rxOutData;
		logic [KEEP_W-1:0]  rxOutKeep;
		logic               rxOutLast;
		logic               rxOutErr;
		logic               rxOutFirst;
		logic               rxStampValid;
		logic [STAMP_W-1:0] rxStampPayload;
	} ptsc_state_t;

	localparam ptsc_state_t ST_RESET = '0;
endpackage

/* File: tb/ptsc_mac_sink.sv */
`timescale 1ns/1ps
// transmit sink on the far side; when told to stall it is ready only on every other cycle
module ptsc_mac_sink (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic stall,
	output logic      txOutReady
);
	always_ff @(posedge mclk) begin
		if (!reset_n)
			txOutReady <= 1'b1;
		else
			txOutReady <= stall ? ~txOutReady : 1'b1;
	end
endmodule

/* File: tb/ptsc_timestamp_if_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module ptsc_timestamp_if_tb_top;
	import ptsc_pkg::*;
	localparam logic [SECS_W-1:0]  SECS  = 48'h0001_2345_6789;
	localparam logic [NANOS_W-1:0] NANOS = 32'h3B9A_C9FF;
	localparam logic [CORR_W-1:0]  CORR  = 64'h0000_0012_3456_8000;
	localparam logic [KEEP_W-1:0]  KEEP  = 8'h3F;
	localparam logic [DATA_W-1:0]  DAT   = 64'h0A0B_0C0D_0E0F_1011;
	logic mclk = 0, reset_n = 0, stall = 0, txOutReady;
	logic ib = 0, tpr = 0, il = 0, rpr = 0;
	logic [DATA_W-1:0] txInData = '0, rxInData = '0, txOutData, rxOutData;
	logic [USER_W-1:0] txInUser = '0;
	logic [STAMP_W-1:0] txPay, rxPay;
	logic txInValid = 0, txInLast = 0, rxInValid = 0, rxInLast = 0, txInReady;
	logic txOutValid, txOutUnderrun, txStampV, rxOutValid, rxStampV;
	logic [KEEP_W-1:0] txKeepO, rxKeepO;
	logic txLastO, rxLastO, rxErrO, rxInErr = 0, txStampVC, rxStampVC;
	logic [STAMP_W-1:0] txPayC, rxPayC;
	logic [DATA_W-1:0] rxOutDataC;
	int n_mismatch = 0, checks_done = 0;

	always #10 mclk = ~mclk;

	ptsc_mac_sink u_sink (.mclk(mclk), .reset_n(reset_n), .stall(stall), .txOutReady(txOutReady));

	ptsc_timestamp_if u_dut (.mclk(mclk), .reset_n(reset_n), .txInbandCmdEn(ib),
		.txPreservePreambleEn(tpr), .rxInlineStampEn(il), .rxPreservePreambleEn(rpr),
		.calendar_nanos_in(NANOS), .calendarSecsIn(SECS), .correctionTimeIn(CORR),
		.txInData(txInData), .txInKeep(KEEP), .txInLast(txInLast), .txInUser(txInUser),
		.txInValid(txInValid), .txInReady(txInReady), .txOutData(txOutData),
		.txOutKeep(txKeepO), .txOutLast(txLastO), .txOutUnderrun(txOutUnderrun),
		.txOutValid(txOutValid),
		.txOutReady(txOutReady), .tx_stamp_payload(txPay), .tx_stamp_valid(txStampV),
		.rxInData(rxInData), .rxInKeep(KEEP), .rxInLast(rxInLast), .rxInErr(rxInErr),
		.rxInValid(rxInValid), .rxOutData(rxOutData), .rxOutKeep(rxKeepO),
		.rxOutLast(rxLastO), .rxOutErr(rxErrO), .rxOutValid(rxOutValid),
		.rx_stamp_payload(rxPay), .rx_stamp_valid(rxStampV));

	// correction-format copy shares every input and the sink, so its flow matches u_dut
	ptsc_timestamp_if #(.CAL_FORMAT(1'b0)) u_dut_corr (.mclk(mclk), .reset_n(reset_n),
		.txInbandCmdEn(ib), .txPreservePreambleEn(tpr), .rxInlineStampEn(il),
		.rxPreservePreambleEn(rpr), .calendar_nanos_in(NANOS), .calendarSecsIn(SECS),
		.correctionTimeIn(CORR), .txInData(txInData), .txInKeep(KEEP), .txInLast(txInLast),
		.txInUser(txInUser), .txInValid(txInValid), .txInReady(), .txOutData(),
		.txOutKeep(), .txOutLast(), .txOutUnderrun(), .txOutValid(),
		.txOutReady(txOutReady), .tx_stamp_payload(txPayC), .tx_stamp_valid(txStampVC),
		.rxInData(rxInData), .rxInKeep(KEEP), .rxInLast(rxInLast), .rxInErr(rxInErr),
		.rxInValid(rxInValid), .rxOutData(rxOutDataC), .rxOutKeep(), .rxOutLast(),
		.rxOutErr(), .rxOutValid(), .rx_stamp_payload(rxPayC), .rx_stamp_valid(rxStampVC));

	task automatic end_sim();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// holds the beat until the block shows ready, so it is taken at the next rising edge
	task automatic beat(input logic [DATA_W-1:0] d, input logic [USER_W-1:0] u, input logic l);
		@(negedge mclk);
		txInValid = 1;
		txInData = d;
		txInUser = u;
		txInLast = l;
		while (txInReady !== 1'b1) @(negedge mclk);
	endtask

	task automatic tx(input logic i, p, input logic [1:0] op, input logic st);
		logic [CMD_W-1:0] cmd;
		logic eff, hit;
		cmd = {32'h0, 16'hA5C0 + 16'(op), 14'h0, op};
		eff = i && !p;
		hit = (op == 2'h1) || (op == 2'h2);
		@(negedge mclk);
		ib = i;
		tpr = p;
		stall = st;
		if (eff) beat(cmd, {USER_W{1'b0}}, 1'b0);
		// in-band frames carry an inverted sideband so a wrong source shows up
		beat(64'h1111_2222_3333_4444, {eff ? ~cmd : cmd, 64'hFFFF_FFFF_FFFF_FFFF}, 1'b1);
		@(negedge mclk);
		txInValid = 0;
		`CHK(txStampV, hit)
		if (hit) `CHK(txPay, {32'h0, cmd[31:16], SECS, NANOS})
		`CHK(txOutValid, 1'b1)
		`CHK(txOutData, 64'h1111_2222_3333_4444)
		`CHK(txOutUnderrun, 1'b1)
		`CHK(txStampVC, hit)
		if (hit) `CHK(txPayC, {32'h0, cmd[31:16], 16'h0, CORR})
		`CHK({txKeepO, txLastO}, {KEEP, 1'b1})
		@(negedge mclk);
		`CHK(txStampV, 1'b0)
		stall = 0;
		repeat (3) @(negedge mclk);
		`CHK(txOutValid, 1'b0)
	endtask

	task automatic rx(input logic i, p);
		logic eff;
		eff = i && !p;
		@(negedge mclk);
		il = i;
		rpr = p;
		@(negedge mclk);
		rxInValid = 1;
		rxInData = DAT;
		rxInLast = 1;
		rxInErr = 1;
		@(negedge mclk);
		rxInValid = 0;
		rxInLast = 0;
		rxInErr = 0;
		`CHK(rxStampV, 1'b1)
		`CHK(rxPay, {48'h0, SECS, NANOS})
		`CHK(rxOutValid, 1'b1)
		`CHK(rxOutData, eff ? {SECS[31:0], NANOS} : DAT)
		`CHK({rxKeepO, rxLastO, rxErrO}, eff ? {8'hFF, 2'b00} : {KEEP, 2'b11})
		`CHK(rxStampVC, 1'b1)
		`CHK(rxPayC, {64'h0, CORR})
		`CHK(rxOutDataC, eff ? CORR : DAT)
		if (eff) begin
			@(negedge mclk);
			`CHK(rxOutData, DAT)
			`CHK({rxKeepO, rxLastO, rxErrO}, {KEEP, 2'b11})
			`CHK(rxOutDataC, DAT)
			`CHK(rxStampV, 1'b0)
		end
		@(negedge mclk);
		`CHK(rxOutValid, 1'b0)
	endtask

	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		repeat (5) @(negedge mclk);
		`CHK({txOutValid, txStampV, rxOutValid, rxStampV, txInReady}, 5'h01)
		reset_n = 1;
		// time input must settle through the synchroniser before a stamp is taken
		repeat (8) @(negedge mclk);
		for (int k = 0; k < 4; k++) tx(1'b0, 1'b0, 2'(k), k[0]);
		for (int k = 0; k < 4; k++) tx(1'b1, 1'b0, 2'(k), k[1]);
		tx(1'b1, 1'b1, 2'h2, 1'b0);
		tx(1'b0, 1'b1, 2'h1, 1'b1);
		rx(1'b0, 1'b0);
		rx(1'b1, 1'b0);
		rx(1'b1, 1'b1);
		rx(1'b1, 1'b0);
		end_sim();
	end
endmodule
